// file: design/gpib_addr_regs.svh
// Register offsets, bit positions, reset values and command codes of the
// address status block. Assumes a host byte port and GPIB command bytes.
//
// What this block does
// - Status change flag sets when talker, listener, controller or major/minor bit changes.
// - Status change flag clears at hardware reset and right after status two is read.
// - Host-written poll status bits clear at power-on and on chip reset.
// - Polled talker sends its status byte once the controller stands by.
// - Pending bit sets when request-service is set, clears once idle with it dropped.
// - Request-service outside a serial poll enters service request and drives SRQ.
// - Request-service clears when the poll byte is read, at power-on and chip reset.
// - Controller bit reads one unless the controller is idle or addressed-idle.
// - Attention bit shows the ATN line level, zero while asserted.
// - Serial poll mode sets on poll enable as talker, clears on disable or resets.
// - Extended listen primary bit sets on primary listen address; resets clear it.
// - Extended talk primary bit sets on primary talk address.
// - Listener bit follows listen addressing or listen-only; resets clear it.
// - Being addressed to listen drops talker addressing; listen-only does not.
// - Talker bit follows talk addressing or talk-only; resets clear it.
// - Major/minor bit sets on minor address, clears on major address.
// - Major/minor bit reads zero outside the two dual addressing modes.
// - Talk-only makes a talker; clearing it alone keeps the talker state.
// - Listen-only makes a listener; clearing it alone keeps the listener state.
// - Address mode selects only-mode, dual, extended single or extended dual.
// - No status change flag while talk-only or listen-only is in effect.
`ifndef GPIB_ADDR_REGS_SVH
`define GPIB_ADDR_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets on the host byte port
// ----------------------------------------------------------------------
`define ADDR_W 12
`define REG_SERIAL_POLL 12'h117
`define REG_ADDRESS 12'h119

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define SP_RSV_BIT 6
`define AM_TON_BIT 7
`define AM_LON_BIT 6
`define SP_RESET 8'h00
`define AM_RESET 8'h00

// ----------------------------------------------------------------------
// Multiline command codes and groups
// ----------------------------------------------------------------------
`define CMD_SPE 8'h18
`define CMD_SPD 8'h19
`define CMD_UNL 8'h3F
`define CMD_UNT 8'h5F
`define GRP_LISTEN 2'h1
`define GRP_TALK 2'h2
`define GRP_SECOND 2'h3
`define ADDR_NONE 5'h1F

`endif

// file: design/gpib_addr_pkg.sv
// Types shared by the address status block.
// Assumes nothing beyond a SystemVerilog compiler.
package gpib_addr_pkg;

   // Addressing modes selected by the two mode bits.
   typedef enum logic [1:0] {
      MODE_ONLY = 2'h0,
      MODE_DUAL = 2'h1,
      MODE_EXT_SINGLE = 2'h2,
      MODE_EXT_DUAL = 2'h3
   } addr_mode_t;

   // Service request states, one-hot.
   typedef enum logic [2:0] {
      SR_NEG = 3'h1,
      SR_REQ = 3'h2,
      SR_AFF = 3'h4
   } sr_state_t;

endpackage

// file: design/cmd_decode.sv
// Combinational decoder of one GPIB multiline command byte.
// Assumes the byte is stable while its strobe is high.
`timescale 1ns/1ns
`include "gpib_addr_regs.svh"
module cmd_decode
   import gpib_addr_pkg::*;
(
   input wire logic [7:0] cmd_byte,
   input wire logic [4:0] major_addr,
   input wire logic [4:0] minor_addr,
   output logic listen_grp,
   output logic talk_grp,
   output logic second_grp,
   output logic hit_major,
   output logic hit_minor,
   output logic is_spe,
   output logic is_spd,
   output logic is_unl,
   output logic is_unt
);

   // Address 31 is the unlisten or untalk code, never a device address.
   function automatic logic addr_hit(input logic [7:0] b, input logic [4:0] a);
      addr_hit = (b[4:0] == a) && (b[4:0] != `ADDR_NONE);
   endfunction

   // ----------------------------------------------------------------------
   // Group and address decode
   // ----------------------------------------------------------------------
   always_comb begin
      listen_grp = (cmd_byte[6:5] == `GRP_LISTEN);
      talk_grp = (cmd_byte[6:5] == `GRP_TALK);
      second_grp = (cmd_byte[6:5] == `GRP_SECOND);
      hit_major = addr_hit(cmd_byte, major_addr);
      hit_minor = addr_hit(cmd_byte, minor_addr);
      is_spe = ({1'b0, cmd_byte[6:0]} == `CMD_SPE);
      is_spd = ({1'b0, cmd_byte[6:0]} == `CMD_SPD);
      is_unl = ({1'b0, cmd_byte[6:0]} == `CMD_UNL);
      is_unt = ({1'b0, cmd_byte[6:0]} == `CMD_UNT);
   end

endmodule

// file: design/gpib_address_status.sv
// Address status, serial poll status and address mode logic of a GPIB
// talker/listener. Assumes all inputs synchronous to clk; command bytes
// arrive with a one-cycle strobe, and controller states come from outside.
`timescale 1ns/1ns
`include "gpib_addr_regs.svh"
module gpib_address_status
   import gpib_addr_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [`ADDR_W-1:0] reg_addr,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic stat_two_read,
   input wire logic chip_reset,
   input wire logic pon_cmd,
   input wire logic local_master_reset,
   input wire logic [4:0] address_slot_zero,
   input wire logic [4:0] address_slot_one,
   input wire logic atn_n,
   input wire logic ctrl_idle,
   input wire logic ctrl_addr_idle,
   input wire logic [7:0] cmd_byte,
   input wire logic cmd_valid,
   input wire logic sec_accept,
   input wire logic poll_taken,
   output logic [7:0] reg_rdata,
   output logic address_status_change_flag,
   output logic srq_out,
   output logic [7:0] poll_byte,
   output logic poll_valid,
   output logic talker_active_bit,
   output logic listener_active_bit,
   output logic [1:0] txrx_pin_mode
);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   logic [7:0] poll_bits_r;
   logic rsv_r;
   logic poll_wait_r;
   logic ton_r;
   logic lon_r;
   addr_mode_t mode_r;
   logic talk_r;
   logic lstn_r;
   logic minor_r;
   logic poll_mode_r;
   logic lprim_r;
   logic tprim_r;
   logic [3:0] stat_prev_r;
   logic sent_r;
   sr_state_t sr_r;
   sr_state_t sr_nxt;

   logic local_rst;
   logic cmd_in;
   logic wr_sp;
   logic wr_am;
   logic rd_stat;
   logic dual;
   logic cic;
   logic minor_vis;
   logic spas;
   logic only_mode;
   logic [3:0] stat;
   logic listen_grp, talk_grp, second_grp, hit_major, hit_minor;
   logic is_spe, is_spd, is_unl, is_unt;
   logic my_listen, my_talk, sec_ok;
   logic lstn_set, lstn_clr, talk_set, talk_clr;

   cmd_decode u_decode (
      .cmd_byte(cmd_byte),
      .major_addr(address_slot_zero),
      .minor_addr(address_slot_one),
      .listen_grp(listen_grp),
      .talk_grp(talk_grp),
      .second_grp(second_grp),
      .hit_major(hit_major),
      .hit_minor(hit_minor),
      .is_spe(is_spe),
      .is_spd(is_spd),
      .is_unl(is_unl),
      .is_unt(is_unt)
   );

   // ----------------------------------------------------------------------
   // Decode of strobes, mode and addressing events
   // ----------------------------------------------------------------------
   // Commands count only while ATN is asserted, i.e. atn_n low.
   always_comb begin
      local_rst = chip_reset | pon_cmd;
      cmd_in = cmd_valid & ~atn_n;
      wr_sp = reg_wr && (reg_addr == `REG_SERIAL_POLL);
      wr_am = reg_wr && (reg_addr == `REG_ADDRESS);
      rd_stat = reg_rd && (reg_addr == `REG_ADDRESS);
      dual = (mode_r == MODE_DUAL) || (mode_r == MODE_EXT_DUAL);
      only_mode = (mode_r == MODE_ONLY);
      cic = ~(ctrl_idle | ctrl_addr_idle);
      minor_vis = minor_r & dual;
      spas = talk_r & poll_mode_r;
      stat = {talk_r, lstn_r, cic, minor_vis};
      my_listen = listen_grp && (hit_major || (dual && hit_minor));
      my_talk = talk_grp && (hit_major || (dual && hit_minor));
      // Extended single checks the secondary itself; extended dual leaves it to software.
      sec_ok = second_grp && ((mode_r == MODE_EXT_SINGLE) ?
               (cmd_byte[4:0] == address_slot_one) : sec_accept);
   end

   // Listener and talker set and clear terms.
   always_comb begin
      lstn_set = 1'b0;
      talk_set = 1'b0;
      lstn_clr = 1'b0;
      talk_clr = 1'b0;
      if (cmd_in && !only_mode) begin
         if (mode_r == MODE_DUAL) begin
            lstn_set = my_listen;
            talk_set = my_talk;
         end else begin
            lstn_set = lprim_r & sec_ok;
            talk_set = tprim_r & sec_ok;
         end
         lstn_clr = is_unl;
         talk_clr = is_unt || (talk_grp && !my_talk);
      end
   end

   // ----------------------------------------------------------------------
   // Address mode register
   // ----------------------------------------------------------------------
   // Reserved and pin-control bits are not checked; the host keeps them right.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ton_r <= 1'b0;
         lon_r <= 1'b0;
         mode_r <= MODE_ONLY;
         txrx_pin_mode <= 2'h0;
      end else if (wr_am) begin
         ton_r <= reg_wdata[`AM_TON_BIT];
         lon_r <= reg_wdata[`AM_LON_BIT];
         txrx_pin_mode <= reg_wdata[5:4];
         mode_r <= addr_mode_t'(reg_wdata[1:0]);
      end
   end

   // ----------------------------------------------------------------------
   // Talker, listener and major/minor
   // ----------------------------------------------------------------------
   // Only-mode bits set the states but never clear them, so the state holds
   // until a reset command after the host drops the bit.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lstn_r <= 1'b0;
         talk_r <= 1'b0;
      end else if (local_rst) begin
         lstn_r <= 1'b0;
         talk_r <= 1'b0;
      end else begin
         if (lon_r || lstn_set) begin
            lstn_r <= 1'b1;
         end else if (lstn_clr) begin
            lstn_r <= 1'b0;
         end
         if (ton_r || (talk_set && !lstn_set)) begin
            talk_r <= 1'b1;
         end else if (talk_clr || lstn_set) begin
            talk_r <= 1'b0;
         end
      end
   end

   // Minor hits only when the major address does not match as well.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         minor_r <= 1'b0;
      end else if (local_rst) begin
         minor_r <= 1'b0;
      end else if (cmd_in && dual && (listen_grp || talk_grp)) begin
         if (hit_major) begin
            minor_r <= 1'b0;
         end else if (hit_minor) begin
            minor_r <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Primary addressed states for extended modes
   // ----------------------------------------------------------------------
   // Any primary command other than our own address ends the primary state.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lprim_r <= 1'b0;
         tprim_r <= 1'b0;
      end else if (local_rst || local_master_reset) begin
         lprim_r <= 1'b0;
         tprim_r <= 1'b0;
      end else if (cmd_in && mode_r[1] && !second_grp) begin
         lprim_r <= my_listen;
         tprim_r <= my_talk;
      end
   end

   // ----------------------------------------------------------------------
   // Serial poll mode
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         poll_mode_r <= 1'b0;
      end else if (local_rst || local_master_reset) begin
         poll_mode_r <= 1'b0;
      end else if (cmd_in && is_spd) begin
         poll_mode_r <= 1'b0;
      end else if (cmd_in && is_spe && talk_r) begin
         poll_mode_r <= 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // Status change flag
   // ----------------------------------------------------------------------
   // A change in the same cycle as the read wins, so no event is lost.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stat_prev_r <= 4'h0;
         address_status_change_flag <= 1'b0;
      end else begin
         stat_prev_r <= stat;
         if ((stat != stat_prev_r) && !(ton_r || lon_r)) begin
            address_status_change_flag <= 1'b1;
         end else if (stat_two_read) begin
            address_status_change_flag <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Serial poll status byte and request service
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         poll_bits_r <= `SP_RESET;
      end else if (local_rst) begin
         poll_bits_r <= `SP_RESET;
      end else if (wr_sp) begin
         poll_bits_r <= reg_wdata;
      end
   end

   // Reading the poll byte in the affirmative state ends the request.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rsv_r <= 1'b0;
      end else if (local_rst) begin
         rsv_r <= 1'b0;
      end else if (wr_sp) begin
         rsv_r <= reg_wdata[`SP_RSV_BIT];
      end else if (poll_taken && poll_valid && (sr_r == SR_AFF)) begin
         rsv_r <= 1'b0;
      end
   end

   // Setting request-service wins over the clear of the same cycle.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         poll_wait_r <= 1'b0;
      end else if (wr_sp && reg_wdata[`SP_RSV_BIT]) begin
         poll_wait_r <= 1'b1;
      end else if ((sr_r == SR_NEG) && !rsv_r) begin
         poll_wait_r <= 1'b0;
      end
   end

   always_comb begin
      case (sr_r)
         SR_NEG: sr_nxt = (rsv_r && !spas) ? SR_REQ : SR_NEG;
         SR_REQ: sr_nxt = spas ? SR_AFF : (rsv_r ? SR_REQ : SR_NEG);
         SR_AFF: sr_nxt = spas ? SR_AFF : SR_NEG;
         default: sr_nxt = SR_NEG;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sr_r <= SR_NEG;
         srq_out <= 1'b0;
      end else if (local_rst) begin
         sr_r <= SR_NEG;
         srq_out <= 1'b0;
      end else begin
         sr_r <= sr_nxt;
         srq_out <= (sr_nxt == SR_REQ);
      end
   end

   // Poll byte goes out once per standby period; ATN assertion re-arms it.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         poll_valid <= 1'b0;
         poll_byte <= 8'h00;
         sent_r <= 1'b0;
      end else if (local_rst || !spas || !atn_n) begin
         poll_valid <= 1'b0;
         sent_r <= 1'b0;
      end else if (poll_valid && poll_taken) begin
         poll_valid <= 1'b0;
         sent_r <= 1'b1;
      end else if (!poll_valid && !sent_r) begin
         poll_valid <= 1'b1;
         poll_byte <= {poll_bits_r[7], (sr_r != SR_NEG), poll_bits_r[5:0]};
      end
   end

   // ----------------------------------------------------------------------
   // Register read port and mirrored outputs
   // ----------------------------------------------------------------------
   // Unmapped addresses read as zero.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (rd_stat) begin
         reg_rdata <= {cic, atn_n, poll_mode_r, lprim_r, tprim_r, lstn_r, talk_r, minor_vis};
      end else if (reg_rd && (reg_addr == `REG_SERIAL_POLL)) begin
         reg_rdata <= {poll_bits_r[7], poll_wait_r, poll_bits_r[5:0]};
      end else if (reg_rd) begin
         reg_rdata <= 8'h00;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         talker_active_bit <= 1'b0;
         listener_active_bit <= 1'b0;
      end else begin
         talker_active_bit <= talk_r;
         listener_active_bit <= lstn_r;
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   chk_status_change_set: assert property (
      (stat != stat_prev_r) && !(ton_r || lon_r) |=> address_status_change_flag)
      else $error("status change did not raise the flag");
   chk_status_change_read: assert property (
      stat_two_read && (stat == stat_prev_r) |=> !address_status_change_flag)
      else $error("flag not cleared by status read");
   chk_only_no_flag: assert property (
      !address_status_change_flag && (ton_r || lon_r) |=> !address_status_change_flag)
      else $error("flag set in only mode");
   chk_poll_bits_reset: assert property (
      chip_reset |=> (poll_bits_r == `SP_RESET) && !rsv_r && !talk_r && !lstn_r)
      else $error("chip reset left state");
   chk_srq_drive: assert property (
      rsv_r && !spas && (sr_r == SR_NEG) && !local_rst |=> srq_out)
      else $error("request service did not drive SRQ");
   chk_rsv_aff_clear: assert property (
      poll_taken && poll_valid && (sr_r == SR_AFF) && !wr_sp |=> !rsv_r ##1 !srq_out)
      else $error("request service not cleared after poll");
   chk_cic_atn_read: assert property (
      rd_stat |=> reg_rdata[7:6] == {$past(cic), $past(atn_n)})
      else $error("controller or attention bit wrong");
   chk_serial_poll_mode_bit_clear: assert property (
      (cmd_in && is_spd) || local_master_reset |=> !poll_mode_r)
      else $error("serial poll mode not cleared");
   chk_listen_drops_talk: assert property (
      lstn_set && !ton_r && !local_rst |=> lstn_r && !talk_r)
      else $error("talker kept when addressed to listen");
   chk_major_minor_bit_read_zero: assert property (
      rd_stat && !dual |=> !reg_rdata[0])
      else $error("major minor visible outside dual mode");
   chk_ton_sticky: assert property (
      talk_r && only_mode && !local_rst |=> talk_r)
      else $error("talker lost without reset");
   chk_poll_byte: assert property (
      spas && atn_n && !poll_valid && !sent_r && !local_rst |=>
      poll_valid && (poll_byte[5:0] == $past(poll_bits_r[5:0])))
      else $error("poll byte not presented");

   cov_poll_done: cover property (poll_valid && poll_taken && (sr_r == SR_AFF));
   cov_flag_set: cover property ($rose(address_status_change_flag));
   cov_ext_listen: cover property (lprim_r ##[1:4] lstn_r);

endmodule

// file: tb/gpib_ctrl_model.sv
// Behavioural controller-in-charge on the far side of the address status block.
// Assumes the bench calls its tasks and that it shares clk with the block.
`timescale 1ns/1ns
module gpib_ctrl_model (
   input wire logic clk,
   input wire logic poll_valid,
   input wire logic [7:0] poll_byte,
   output logic atn_n,
   output logic [7:0] cmd_byte,
   output logic cmd_valid,
   output logic sec_accept,
   output logic poll_taken
);
   // The bus starts idle with ATN released.
   initial begin
      atn_n = 1'b1;
      cmd_byte = 8'hFF;
      cmd_valid = 1'b0;
      sec_accept = 1'b0;
      poll_taken = 1'b0;
   end

   // One command byte under ATN; afterwards the lines show the inverse so a stale byte
   // can never pass for a fresh one.
   task automatic send_cmd(input logic [7:0] b, input logic sa);
      @(posedge clk);
      #1;
      atn_n = 1'b0;
      cmd_byte = b;
      cmd_valid = 1'b1;
      sec_accept = sa;
      @(posedge clk);
      #1;
      cmd_valid = 1'b0;
      sec_accept = 1'b0;
      cmd_byte = ~b;
      repeat (3) @(posedge clk);
      #1;
   endtask

   // Go to standby so a polled talker may send.
   task automatic standby();
      @(posedge clk);
      #1;
      atn_n = 1'b1;
   endtask

   // Wait a bounded time for the status byte, then accept it for one cycle.
   task automatic take_poll(output logic [7:0] b);
      int n;
      n = 0;
      while (poll_valid !== 1'b1 && n < 10) begin
         @(posedge clk);
         #1;
         n++;
      end
      b = (poll_valid === 1'b1) ? poll_byte : 8'hXX;
      poll_taken = 1'b1;
      @(posedge clk);
      #1;
      poll_taken = 1'b0;
   endtask
endmodule

// file: tb/gpib_address_status_tb.sv
// Self-checking bench of the address status block through its byte registers.
// Assumes the controller model drives the command side and answers polls.
`timescale 1ns/1ns
`include "gpib_addr_regs.svh"
module gpib_address_status_tb;
   logic clk, rst, reg_rd, reg_wr, stat_two_read, chip_reset, pon_cmd, local_master_reset;
   logic ctrl_idle, ctrl_addr_idle, atn_n, cmd_valid, sec_accept, poll_taken, poll_valid;
   logic address_status_change_flag, srq_out, talker_active_bit, listener_active_bit;
   logic [`ADDR_W-1:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, poll_byte, cmd_byte, pb;
   logic [4:0] address_slot_zero, address_slot_one;
   logic [1:0] txrx_pin_mode;
   int err_count, n_tests;

   gpib_address_status gpib_address_status_inst (.clk, .rst, .reg_addr, .reg_rd, .reg_wr,
      .reg_wdata, .stat_two_read, .chip_reset, .pon_cmd, .local_master_reset, .address_slot_zero,
      .address_slot_one, .atn_n, .ctrl_idle, .ctrl_addr_idle, .cmd_byte, .cmd_valid,
      .sec_accept, .poll_taken, .reg_rdata, .address_status_change_flag, .srq_out, .poll_byte,
      .poll_valid, .talker_active_bit, .listener_active_bit, .txrx_pin_mode);
   gpib_ctrl_model gpib_ctrl_model_inst (.clk, .poll_valid, .poll_byte, .atn_n, .cmd_byte,
      .cmd_valid, .sec_accept, .poll_taken);

   // ------------------------------------------------------------
   // Clock, watchdog and verdict
   // ------------------------------------------------------------
   // Free-running 100 MHz clock.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // The tests need well under 1000 cycles; a tenfold margin catches a hang.
   initial begin
      #100000;
      err_count++;
      conclude();
   end
   task automatic conclude();
      if (err_count == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Compares and host port tasks
   // ------------------------------------------------------------
   // Bits outside the mask are not judged.
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
      n_tests++;
      if ((got & m) !== (exp & m)) begin
         err_count++;
         $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp1(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t bit %b expected %b", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [`ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk);
      #1;
      reg_wr = 1'b0;
   endtask
   // Read data is registered, so it is judged one cycle after the strobe.
   task automatic rd(input logic [`ADDR_W-1:0] a, input logic [7:0] exp, input logic [7:0] m);
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk);
      #1;
      reg_rd = 1'b0;
      cmp8(reg_rdata, exp, m);
   endtask
   task automatic pulse(ref logic s);
      @(posedge clk);
      #1;
      s = 1'b1;
      @(posedge clk);
      #1;
      s = 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask

   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial begin
      {rst, ctrl_idle} = 2'h3;
      {reg_rd, reg_wr, stat_two_read, chip_reset, pon_cmd, local_master_reset} = 6'h00;
      {ctrl_addr_idle, reg_addr, reg_wdata} = '0;
      address_slot_zero = 5'h05;
      address_slot_one = 5'h09;
      err_count = 0;
      n_tests = 0;
      repeat (12) @(posedge clk);
      #1;
      rst = 1'b0;
      rd(`REG_ADDRESS, 8'h40, 8'hFF);
      rd(`REG_SERIAL_POLL, 8'h00, 8'hFF);
      rd(12'h100, 8'h00, 8'hFF);
      // Dual addressing: minor talker, then major listener drops the talker.
      wr(`REG_ADDRESS, 8'h31);
      cmp8({6'h00, txrx_pin_mode}, 8'h03, 8'hFF);
      gpib_ctrl_model_inst.send_cmd(8'h49, 1'b0);
      rd(`REG_ADDRESS, 8'h03, 8'hFF);
      cmp1(address_status_change_flag, 1'b1);
      pulse(stat_two_read);
      cmp1(address_status_change_flag, 1'b0);
      gpib_ctrl_model_inst.send_cmd(8'h25, 1'b0);
      rd(`REG_ADDRESS, 8'h04, 8'hFF);
      cmp1(talker_active_bit, 1'b0);
      // Service request, then a full serial poll.
      wr(`REG_SERIAL_POLL, 8'hC5);
      repeat (3) @(posedge clk);
      #1;
      cmp1(srq_out, 1'b1);
      rd(`REG_SERIAL_POLL, 8'hC5, 8'hFF);
      gpib_ctrl_model_inst.send_cmd(`CMD_UNL, 1'b0);
      gpib_ctrl_model_inst.send_cmd(8'h45, 1'b0);
      gpib_ctrl_model_inst.send_cmd(`CMD_SPE, 1'b0);
      cmp1(srq_out, 1'b0);
      rd(`REG_ADDRESS, 8'h22, 8'hFF);
      gpib_ctrl_model_inst.standby();
      gpib_ctrl_model_inst.take_poll(pb);
      cmp8(pb, 8'hC5, 8'hFF);
      rd(`REG_ADDRESS, 8'h62, 8'hFF);
      cmp1(poll_valid, 1'b0);
      gpib_ctrl_model_inst.send_cmd(`CMD_SPD, 1'b0);
      rd(`REG_ADDRESS, 8'h02, 8'hFF);
      rd(`REG_SERIAL_POLL, 8'h85, 8'hFF);
      // Chip reset wipes the poll byte and the talker.
      wr(`REG_SERIAL_POLL, 8'hFF);
      pulse(chip_reset);
      rd(`REG_SERIAL_POLL, 8'h00, 8'hFF);
      rd(`REG_ADDRESS, 8'h00, 8'hFF);
      cmp1(srq_out, 1'b0);
      // Talk-only, then listen-only; addresses are ignored and no change is flagged.
      for (int i = 0; i < 2; i++) begin
         pulse(stat_two_read);
         wr(`REG_ADDRESS, (i == 0) ? 8'hB0 : 8'h70);
         gpib_ctrl_model_inst.send_cmd(8'h25, 1'b0);
         wr(`REG_ADDRESS, 8'h30);
         repeat (3) @(posedge clk);
         cmp1(talker_active_bit, i == 0);
         cmp1(listener_active_bit, i == 1);
         cmp1(address_status_change_flag, 1'b0);
         if (i == 0) begin
            pulse(chip_reset);
         end else begin
            pulse(pon_cmd);
         end
         cmp1(talker_active_bit | listener_active_bit, 1'b0);
      end
      // Extended single addressing: primary then own secondary.
      wr(`REG_ADDRESS, 8'h32);
      gpib_ctrl_model_inst.send_cmd(8'h25, 1'b0);
      rd(`REG_ADDRESS, 8'h10, 8'hFF);
      gpib_ctrl_model_inst.send_cmd(8'h69, 1'b0);
      cmp1(listener_active_bit, 1'b1);
      gpib_ctrl_model_inst.send_cmd(8'h45, 1'b0);
      rd(`REG_ADDRESS, 8'h08, 8'h09);
      pulse(local_master_reset);
      rd(`REG_ADDRESS, 8'h00, 8'h38);
      // Extended dual addressing: minor primary, secondary accepted by software.
      wr(`REG_ADDRESS, 8'h33);
      gpib_ctrl_model_inst.send_cmd(`CMD_UNL, 1'b0);
      gpib_ctrl_model_inst.send_cmd(8'h29, 1'b0);
      gpib_ctrl_model_inst.send_cmd(8'h60, 1'b1);
      rd(`REG_ADDRESS, 8'h05, 8'h05);
      // Controller leaves idle, then goes addressed-idle.
      pulse(stat_two_read);
      ctrl_idle = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      cmp1(address_status_change_flag, 1'b1);
      rd(`REG_ADDRESS, 8'h80, 8'h80);
      ctrl_addr_idle = 1'b1;
      rd(`REG_ADDRESS, 8'h00, 8'h80);
      conclude();
   end
endmodule
